// file: hdl/dpdc_pkg.sv
package dpdc_pkg;
  // ****************************************
  // clock and timing figures
  // ****************************************
  localparam int CLK_PERIOD_PS = 10000;
  localparam int T_CS_HOLD_AFTER_CKE_FALL_PS = 5000;
  localparam int T_CLOCK_HOLD_AFTER_CKE_FALL_PS = 5000;
  localparam int T_CLOCK_STABLE_BEFORE_CKE_RISE_PS = 1750;
  localparam int T_CKE_MIN_PS = 7500;
  localparam int T_XP_PS = 7500;
  localparam int T_DQSCK_MAX_PS = 3600;
  localparam int T_DQSS_MAX_PS = 1250;
  localparam int T_DQS2DQ_MAX_PS = 800;
  localparam int T_WR_PS = 18000;
  localparam int T_MODE_WRITE_TO_CKE_PS = 14000;
  localparam int T_REFRESH_LIMIT_PS = 3904000;
  localparam int READ_LATENCY = 14;
  localparam int WRITE_LATENCY = 8;
  localparam int BURST_LENGTH = 16;
  localparam int WRITE_RECOVERY_CYC = 6;
  localparam int POSTAMBLE_SHORT_CYC = 1;
  localparam int POSTAMBLE_LONG_CYC = 2;
  localparam int AP_EXTRA_CYC = 2;
  localparam int TERM_FIELD_LSB = 4;
  localparam int TERM_FIELD_MSB = 6;
  localparam int POSTAMBLE_BIT = 7;
  localparam int DQ_TERM_FIELD_LSB = 0;
  localparam int DQ_TERM_FIELD_MSB = 2;

  // least time, rounded up, at least one cycle
  function automatic int cyc_up(input int t_ps);
    int c;
    c = (t_ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction : cyc_up

  localparam int CS_HOLD_CYC = cyc_up(T_CS_HOLD_AFTER_CKE_FALL_PS);
  localparam int CLOCK_HOLD_CYC = cyc_up(T_CLOCK_HOLD_AFTER_CKE_FALL_PS);
  localparam int CLOCK_STABLE_CYC = cyc_up(T_CLOCK_STABLE_BEFORE_CKE_RISE_PS);
  localparam int CKE_MIN_CYC = cyc_up(T_CKE_MIN_PS);
  localparam int XP_CYC = cyc_up(T_XP_PS);
  localparam int READ_TO_CKE_CYC = READ_LATENCY + cyc_up(T_DQSCK_MAX_PS) + BURST_LENGTH / 2;
  localparam int WRITE_TO_CKE_CYC = WRITE_LATENCY + cyc_up(T_DQSS_MAX_PS + T_DQS2DQ_MAX_PS)
                                    + BURST_LENGTH / 2;
  localparam int MODE_WRITE_TO_CKE_CYC = cyc_up(T_MODE_WRITE_TO_CKE_PS);
  localparam int REFRESH_LIMIT_CYC = T_REFRESH_LIMIT_PS / CLK_PERIOD_PS;

  // ****************************************
  // link commands and states
  // ****************************************
  typedef enum logic [3:0] {
    DPDC_CMD_NOP, DPDC_CMD_ACT, DPDC_CMD_PRE, DPDC_CMD_REF, DPDC_CMD_RD, DPDC_CMD_RDA,
    DPDC_CMD_WR, DPDC_CMD_WRA, DPDC_CMD_MRR, DPDC_CMD_MRW, DPDC_CMD_OSC
  } dpdc_cmd_e;

  typedef enum logic [1:0] {
    DPDC_MODE_IDLE, DPDC_MODE_ACTIVE, DPDC_MODE_SELF_REFRESH
  } dpdc_mode_e;

  typedef logic [9:0] dpdc_cnt_t;
endpackage : dpdc_pkg

// file: hdl/dpdc_link_if.sv
`timescale 1ns/1ns
`default_nettype none
interface dpdc_link_if;
  logic cke;
  logic cs;
  logic [5:0] ca;
  logic ck_run;

  modport ctrl (output cke, output cs, output ca, output ck_run);
  modport dev (input cke, input cs, input ca, input ck_run);
endinterface : dpdc_link_if
`default_nettype wire

// file: hdl/dpdc_device.sv
`timescale 1ns/1ns
`default_nettype none
module dpdc_device
  import dpdc_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  dpdc_link_if.dev link,
  input wire logic rows_open_in,
  input wire logic self_refresh_in,
  input wire logic row_op_busy_in,
  input wire logic write_burst_in,
  input wire logic [7:0] termination_config_register_in,
  input wire logic termination_rank_enable_in,
  output logic power_down_out,
  output dpdc_mode_e pd_mode_out,
  output logic io_buffers_en_out,
  output logic receivers_en_out,
  output logic refresh_run_out,
  output logic pd_current_valid_out,
  output logic ca_term_on_out,
  output logic dq_term_on_out,
  output logic resume_out,
  output dpdc_mode_e resume_mode_out
);
  // ****************************************
  // power-down state
  // ****************************************
  logic pd;
  dpdc_cnt_t hold_cnt;
  logic [2:0] dq_term_cfg;

  assign dq_term_cfg = termination_config_register_in[DQ_TERM_FIELD_MSB:DQ_TERM_FIELD_LSB];

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      pd <= 1'b0;
    end else if (ce_in) begin
      if (!pd && !link.cke && !link.cs) begin
        pd <= 1'b1;
      end else if (pd && link.cke) begin
        pd <= 1'b0;
      end
    end
  end

  // entry flavour captured at the falling edge of cke
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      pd_mode_out <= DPDC_MODE_IDLE;
    end else if (ce_in && !pd && !link.cke && !link.cs) begin
      if (self_refresh_in) begin
        pd_mode_out <= DPDC_MODE_SELF_REFRESH;
      end else if (rows_open_in) begin
        pd_mode_out <= DPDC_MODE_ACTIVE;
      end else begin
        pd_mode_out <= DPDC_MODE_IDLE;
      end
    end
  end

  // receivers stay alive for CLOCK_HOLD_CYC cycles after entry, whether or not the clock runs
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      hold_cnt <= '0;
    end else if (ce_in) begin
      if (!pd) begin
        hold_cnt <= '0;
      end else if (hold_cnt != dpdc_cnt_t'(CLOCK_HOLD_CYC)) begin
        hold_cnt <= hold_cnt + 10'h001;
      end
    end
  end

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      resume_out <= 1'b0;
      resume_mode_out <= DPDC_MODE_IDLE;
    end else if (ce_in) begin
      resume_out <= pd && link.cke;
      if (pd && link.cke) begin
        resume_mode_out <= pd_mode_out;
      end
    end
  end

  // ****************************************
  // buffer, receiver, refresh and termination controls
  // ****************************************
  assign power_down_out = pd;
  assign io_buffers_en_out = !pd;
  assign receivers_en_out = !(pd && hold_cnt == dpdc_cnt_t'(CLOCK_HOLD_CYC));
  assign refresh_run_out = self_refresh_in && (!pd || pd_mode_out == DPDC_MODE_SELF_REFRESH);
  // open activate/precharge/refresh finish first; low current only after
  assign pd_current_valid_out = pd && !row_op_busy_in;
  assign ca_term_on_out = (termination_config_register_in[TERM_FIELD_MSB:TERM_FIELD_LSB] != 3'h0)
                          && termination_rank_enable_in;
  assign dq_term_on_out = (dq_term_cfg != 3'h0) && write_burst_in && !pd && !self_refresh_in;
endmodule : dpdc_device
`default_nettype wire

// file: hdl/dpdc_controller.sv
`timescale 1ns/1ns
`default_nettype none
module dpdc_controller
  import dpdc_pkg::*;
#(
  parameter int REFRESH_LIMIT = REFRESH_LIMIT_CYC
)
(
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  dpdc_link_if.ctrl link,
  input wire logic cmd_valid_in,
  input wire dpdc_cmd_e cmd_in,
  input wire logic osc_done_in,
  input wire logic pd_req_in,
  input wire logic wake_req_in,
  input wire logic clk_stop_req_in,
  input wire logic self_refresh_in,
  input wire logic [7:0] burst_preamble_config_register_in,
  output logic cmd_ready_out,
  output logic pd_ready_out,
  output logic in_power_down_out,
  output logic clk_change_ok_out
);
  // ****************************************
  // helpers
  // ****************************************
  function automatic dpdc_cnt_t max_cnt(input dpdc_cnt_t a, input dpdc_cnt_t b);
    return (a > b) ? a : b;
  endfunction : max_cnt

  function automatic dpdc_cnt_t dec_cnt(input dpdc_cnt_t a);
    return (a != '0) ? a - 10'h001 : a;
  endfunction : dec_cnt

  typedef enum logic [2:0] {
    DPDC_ST_ACTIVE, DPDC_ST_ENTER, DPDC_ST_SLEEP, DPDC_ST_CLK_STABLE, DPDC_ST_EXIT
  } dpdc_state_e;

  localparam dpdc_cnt_t READ_GAP = dpdc_cnt_t'(READ_TO_CKE_CYC);
  localparam dpdc_cnt_t WRITE_GAP = dpdc_cnt_t'(WRITE_TO_CKE_CYC + cyc_up(T_WR_PS));
  localparam dpdc_cnt_t WRITE_AP_GAP = dpdc_cnt_t'(WRITE_TO_CKE_CYC + WRITE_RECOVERY_CYC
                                                    + AP_EXTRA_CYC + 1);
  localparam dpdc_cnt_t ENTER_GAP = dpdc_cnt_t'((CS_HOLD_CYC > CLOCK_HOLD_CYC) ?
                                                 CS_HOLD_CYC : CLOCK_HOLD_CYC);
  localparam dpdc_cnt_t EXIT_GAP = dpdc_cnt_t'((CKE_MIN_CYC > XP_CYC) ? CKE_MIN_CYC : XP_CYC);

  dpdc_state_e state;
  dpdc_state_e next_state;
  dpdc_cnt_t busy_cnt;
  dpdc_cnt_t next_busy;
  dpdc_cnt_t phase_cnt;
  logic [31:0] sleep_cnt;
  logic osc_run;
  logic take_cmd;
  logic phase_done;
  logic too_long;
  dpdc_cnt_t read_gap_now;

  // ****************************************
  // command acceptance and busy window
  // ****************************************
  assign cmd_ready_out = (state == DPDC_ST_ACTIVE) && (phase_cnt == '0) && !pd_req_in;
  assign take_cmd = ce_in && cmd_valid_in && cmd_ready_out && (cmd_in != DPDC_CMD_NOP);
  assign read_gap_now = READ_GAP + (burst_preamble_config_register_in[POSTAMBLE_BIT] ?
                        dpdc_cnt_t'(POSTAMBLE_LONG_CYC) : dpdc_cnt_t'(POSTAMBLE_SHORT_CYC));

  always_comb begin
    next_busy = dec_cnt(busy_cnt);
    if (take_cmd) begin
      unique case (cmd_in)
        DPDC_CMD_RD, DPDC_CMD_RDA, DPDC_CMD_MRR: next_busy = max_cnt(next_busy, read_gap_now);
        DPDC_CMD_WR: next_busy = max_cnt(next_busy, WRITE_GAP);
        DPDC_CMD_WRA: next_busy = max_cnt(next_busy, WRITE_AP_GAP);
        DPDC_CMD_MRW: next_busy = max_cnt(next_busy, dpdc_cnt_t'(MODE_WRITE_TO_CKE_CYC));
        default: next_busy = next_busy;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      busy_cnt <= '0;
    end else if (ce_in) begin
      busy_cnt <= next_busy;
    end
  end

  // strobe oscillator run holds off power-down until it reports done
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      osc_run <= 1'b0;
    end else if (ce_in) begin
      if (take_cmd && cmd_in == DPDC_CMD_OSC) begin
        osc_run <= 1'b1;
      end else if (osc_done_in) begin
        osc_run <= 1'b0;
      end
    end
  end

  assign pd_ready_out = (state == DPDC_ST_ACTIVE) && (busy_cnt == '0) && !osc_run
                        && (phase_cnt == '0);

  // ****************************************
  // power-down sequencer
  // ****************************************
  assign phase_done = (phase_cnt == '0);
  // self-refresh keeps its own refresh; plain sleep must wake for refresh
  assign too_long = !self_refresh_in && (sleep_cnt >= 32'(REFRESH_LIMIT));

  always_comb begin
    next_state = state;
    unique case (state)
      DPDC_ST_ACTIVE: if (pd_req_in && pd_ready_out && ce_in) next_state = DPDC_ST_ENTER;
      DPDC_ST_ENTER: if (phase_done) next_state = DPDC_ST_SLEEP;
      DPDC_ST_SLEEP: if (phase_done && (wake_req_in || too_long)) next_state = DPDC_ST_CLK_STABLE;
      DPDC_ST_CLK_STABLE: if (phase_done) next_state = DPDC_ST_EXIT;
      DPDC_ST_EXIT: if (phase_done) next_state = DPDC_ST_ACTIVE;
    endcase
  end

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state <= DPDC_ST_ACTIVE;
    end else if (ce_in) begin
      state <= next_state;
    end
  end

  // phase timer reloads on each state change and counts down to zero
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      phase_cnt <= '0;
    end else if (ce_in) begin
      if (next_state != state) begin
        unique case (next_state)
          DPDC_ST_ENTER: phase_cnt <= ENTER_GAP - 10'h001;
          DPDC_ST_SLEEP: phase_cnt <= dpdc_cnt_t'(CKE_MIN_CYC) - 10'h001;
          DPDC_ST_CLK_STABLE: phase_cnt <= dpdc_cnt_t'(CLOCK_STABLE_CYC) - 10'h001;
          DPDC_ST_EXIT: phase_cnt <= EXIT_GAP - 10'h001;
          default: phase_cnt <= '0;
        endcase
      end else begin
        phase_cnt <= dec_cnt(phase_cnt);
      end
    end
  end

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      sleep_cnt <= '0;
    end else if (ce_in) begin
      if (state == DPDC_ST_SLEEP) begin
        sleep_cnt <= sleep_cnt + 32'h00000001;
      end else begin
        sleep_cnt <= '0;
      end
    end
  end

  // ****************************************
  // link drive
  // ****************************************
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      link.cke <= 1'b1;
      link.cs <= 1'b0;
      link.ca <= 6'h00;
      link.ck_run <= 1'b1;
    end else if (ce_in) begin
      link.cke <= !(next_state == DPDC_ST_ENTER || next_state == DPDC_ST_SLEEP
                    || next_state == DPDC_ST_CLK_STABLE);
      // cs low and ca quiet through entry and sleep
      link.cs <= take_cmd;
      link.ca <= take_cmd ? {2'h0, cmd_in} : 6'h00;
      // clock may stop only deep in sleep, never in the guarded windows
      link.ck_run <= !(next_state == DPDC_ST_SLEEP && state == DPDC_ST_SLEEP
                       && clk_stop_req_in && !wake_req_in && !too_long);
    end
  end

  assign in_power_down_out = (state == DPDC_ST_SLEEP);
  assign clk_change_ok_out = (state == DPDC_ST_SLEEP) && phase_done;
endmodule : dpdc_controller
`default_nettype wire

// file: sim/dpdc_link_chk.sv
`timescale 1ns/1ns
`default_nettype none
module dpdc_link_chk
  import dpdc_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic cke_in,
  input wire logic cs_in,
  input wire logic [5:0] ca_in,
  input wire logic ck_run_in
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  // ****************************************
  // burst guard count
  // ****************************************
  // short postamble assumed: select bit is not on the link
  dpdc_cnt_t gap;
  dpdc_cnt_t next_gap;
  always_comb begin
    next_gap = (gap != '0) ? gap - 10'h001 : gap;
    if (cs_in) begin
      case (ca_in[3:0])
        DPDC_CMD_RD, DPDC_CMD_RDA, DPDC_CMD_MRR: next_gap = dpdc_cnt_t'(READ_TO_CKE_CYC + POSTAMBLE_SHORT_CYC - 1);
        DPDC_CMD_WR: next_gap = dpdc_cnt_t'(WRITE_TO_CKE_CYC + cyc_up(T_WR_PS) - 1);
        DPDC_CMD_WRA: next_gap = dpdc_cnt_t'(WRITE_TO_CKE_CYC + WRITE_RECOVERY_CYC + AP_EXTRA_CYC);
        default: next_gap = next_gap;
      endcase
    end
  end
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      gap <= '0;
    end else begin
      gap <= next_gap;
    end
  end
  // ****************************************
  // link assertions
  // ****************************************
  cs_hold_low_a: assert property ($fell(cke_in) |-> !cs_in ##1 !cs_in)
    else $error("cs not held low after cke fall");
  cke_low_min_a: assert property ($fell(cke_in) |-> !cke_in [*3])
    else $error("cke low too short");
  clock_hold_a: assert property ($fell(cke_in) |-> ck_run_in ##1 ck_run_in)
    else $error("clock stopped at cke fall");
  clock_stable_a: assert property ($rose(cke_in) |-> $past(ck_run_in) && ck_run_in ##1 ck_run_in)
    else $error("clock not stable around cke rise");
  cke_high_min_a: assert property ($rose(cke_in) |-> cke_in [*2])
    else $error("cke high too short");
  exit_quiet_a: assert property ($rose(cke_in) |-> !cs_in [*2])
    else $error("command inside exit latency");
  asleep_no_cmd_a: assert property (!cke_in |-> !cs_in)
    else $error("command while cke low");
  burst_gap_a: assert property ($fell(cke_in) |-> gap == '0)
    else $error("cke fell inside data burst");
  clock_stop_a: assert property (!ck_run_in |-> !cke_in ##1 !cke_in)
    else $error("clock stopped outside sleep");
endmodule : dpdc_link_chk
`default_nettype wire

// file: sim/tb_dram_power_down_control.sv
`timescale 1ns/1ns
`default_nettype none
`define TB_CHK(a, e) begin check_count++; if ((a) !== (e)) begin error_cnt++; $display("unexpected %0t %h %h", $time, a, e); end end
`define TB_WAIT(c) begin for (w = 0; w < 64 && !(c); w++) step(); if (w == 64) begin error_cnt++; complete_run(); end end
module tb_dram_power_down_control
  import dpdc_pkg::*;
;
  // short refresh cap keeps the run brief
  localparam int REF_LIM = 20;
  logic ref_clk_in, reset_in, cmd_valid, osc_done, pd_req, wake_req, clk_stop, self_ref;
  logic rows_open, row_busy, wr_burst, rank_en, ce;
  logic cmd_ready, pd_ready, in_pd, clk_ok, power_down, io_en, rx_en, ref_run, cur_ok, ca_term, dq_term, resume;
  logic [7:0] b_cfg, t_cfg;
  dpdc_cmd_e cmd;
  dpdc_mode_e pd_mode, resume_mode;
  int error_cnt, check_count, w;
  dpdc_link_if link ();
  dpdc_controller #(.REFRESH_LIMIT(REF_LIM)) i_dpdc_controller (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
    .ce_in(ce), .link(link), .cmd_valid_in(cmd_valid), .cmd_in(cmd), .osc_done_in(osc_done), .pd_req_in(pd_req),
    .wake_req_in(wake_req), .clk_stop_req_in(clk_stop), .self_refresh_in(self_ref),
    .burst_preamble_config_register_in(b_cfg), .cmd_ready_out(cmd_ready), .pd_ready_out(pd_ready),
    .in_power_down_out(in_pd), .clk_change_ok_out(clk_ok));
  dpdc_device i_dpdc_device (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .ce_in(ce), .link(link),
    .rows_open_in(rows_open), .self_refresh_in(self_ref), .row_op_busy_in(row_busy), .write_burst_in(wr_burst),
    .termination_config_register_in(t_cfg), .termination_rank_enable_in(rank_en), .power_down_out(power_down),
    .pd_mode_out(pd_mode), .io_buffers_en_out(io_en), .receivers_en_out(rx_en), .refresh_run_out(ref_run),
    .pd_current_valid_out(cur_ok), .ca_term_on_out(ca_term), .dq_term_on_out(dq_term), .resume_out(resume),
    .resume_mode_out(resume_mode));
  dpdc_link_chk i_dpdc_link_chk (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .cke_in(link.cke),
    .cs_in(link.cs), .ca_in(link.ca), .ck_run_in(link.ck_run));
  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  // ****************************************
  // shared steps
  // ****************************************
  task automatic step();
    @(posedge ref_clk_in);
    #1;
  endtask : step
  task automatic complete_run();
    if (error_cnt == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run
  task automatic issue(input dpdc_cmd_e c);
    cmd = c;
    cmd_valid = 1'b1;
    `TB_WAIT(cmd_ready)
    step();
    cmd_valid = 1'b0;
  endtask : issue
  task automatic enter();
    pd_req = 1'b1;
    `TB_WAIT(in_pd)
    pd_req = 1'b0;
  endtask : enter
  task automatic leave(input dpdc_mode_e m);
    wake_req = 1'b1;
    `TB_WAIT(resume)
    `TB_CHK(resume_mode, m)
    wake_req = 1'b0;
    `TB_WAIT(cmd_ready)
    `TB_CHK(link.cke, 1'b1)
  endtask : leave
  // ****************************************
  // scenarios
  // ****************************************
  // w counts from the cs cycle to sleep, one past the cke fall
  task automatic gap(input dpdc_cmd_e c, input logic b7, input int n);
    b_cfg = {b7, 7'h00};
    issue(c);
    enter();
    `TB_CHK(w > n, 1'b1)
    leave(DPDC_MODE_IDLE);
  endtask : gap
  task automatic osc_hold();
    issue(DPDC_CMD_OSC);
    pd_req = 1'b1;
    repeat (8) step();
    `TB_CHK(link.cke, 1'b1)
    `TB_CHK(pd_ready, 1'b0)
    osc_done = 1'b1;
    step();
    osc_done = 1'b0;
    enter();
    leave(DPDC_MODE_IDLE);
  endtask : osc_hold
  task automatic flavour(input logic sr, input logic rows, input dpdc_mode_e m);
    self_ref = sr;
    rows_open = rows;
    issue(rows ? DPDC_CMD_ACT : DPDC_CMD_REF);
    row_busy = 1'b1;
    clk_stop = 1'b1;
    enter();
    step();
    step();
    `TB_CHK(power_down, 1'b1)
    `TB_CHK(pd_mode, m)
    `TB_CHK(io_en, 1'b0)
    `TB_CHK(rx_en, 1'b0)
    `TB_CHK(ref_run, sr)
    `TB_CHK(ca_term, 1'b1)
    `TB_CHK(dq_term, 1'b0)
    `TB_CHK(cur_ok, 1'b0)
    row_busy = 1'b0;
    step();
    `TB_CHK(cur_ok, 1'b1)
    `TB_CHK(link.ck_run, 1'b0)
    `TB_CHK(clk_ok, 1'b1)
    clk_stop = 1'b0;
    leave(m);
    self_ref = 1'b0;
    rows_open = 1'b0;
  endtask : flavour
  task automatic refresh_cap();
    enter();
    `TB_WAIT(resume)
    `TB_CHK(w + 2 >= REF_LIM && w <= REF_LIM + 6, 1'b1)
    `TB_WAIT(cmd_ready)
  endtask : refresh_cap
  // a wake request must wait while the enable holds everything still
  task automatic freeze();
    enter();
    wake_req = 1'b1;
    ce = 1'b0;
    repeat (4) step();
    `TB_CHK(link.cke, 1'b0)
    `TB_CHK(power_down, 1'b1)
    ce = 1'b1;
    leave(DPDC_MODE_IDLE);
  endtask : freeze
  initial begin
    error_cnt = 0;
    check_count = 0;
    w = 0;
    {reset_in, cmd_valid, osc_done, pd_req, wake_req, clk_stop, self_ref} = 7'h40;
    {rows_open, row_busy, wr_burst, rank_en} = 4'h3;
    ce = 1'b1;
    cmd = DPDC_CMD_NOP;
    b_cfg = 8'h00;
    t_cfg = 8'h11;
    repeat (6) @(posedge ref_clk_in);
    #1;
    reset_in = 1'b0;
    `TB_CHK(link.cke, 1'b1)
    `TB_CHK(power_down, 1'b0)
    `TB_CHK(io_en, 1'b1)
    `TB_CHK(rx_en, 1'b1)
    `TB_CHK(dq_term, 1'b1)
    gap(DPDC_CMD_RD, 1'b0, READ_TO_CKE_CYC + POSTAMBLE_SHORT_CYC);
    gap(DPDC_CMD_RDA, 1'b1, READ_TO_CKE_CYC + POSTAMBLE_LONG_CYC);
    gap(DPDC_CMD_MRR, 1'b1, READ_TO_CKE_CYC + POSTAMBLE_LONG_CYC);
    gap(DPDC_CMD_WR, 1'b0, WRITE_TO_CKE_CYC + (T_WR_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    gap(DPDC_CMD_WRA, 1'b0, WRITE_TO_CKE_CYC + WRITE_RECOVERY_CYC + AP_EXTRA_CYC + 1);
    gap(DPDC_CMD_MRW, 1'b0, MODE_WRITE_TO_CKE_CYC);
    osc_hold();
    flavour(1'b0, 1'b0, DPDC_MODE_IDLE);
    flavour(1'b0, 1'b1, DPDC_MODE_ACTIVE);
    flavour(1'b1, 1'b0, DPDC_MODE_SELF_REFRESH);
    refresh_cap();
    freeze();
    enter();
    reset_in = 1'b1;
    step();
    `TB_CHK(link.cke, 1'b1)
    reset_in = 1'b0;
    step();
    `TB_CHK(power_down, 1'b0)
    `TB_CHK(in_pd, 1'b0)
    complete_run();
  end
endmodule : tb_dram_power_down_control
`default_nettype wire
